// ===== dv/lcd_panel_model.sv
// passive glass model: flags pixels that see the full rail-to-rail swing
`default_nettype none
module lcd_panel_model (
    // drive levels
    input wire logic [7:0] common_lvl_ff,
    input wire logic [3:0] common_open_ff,
    input wire logic [79:0] segment_lvl_ff,
    // pixel state, common c segment s at c*40+s
    output logic [159:0] full_on
);
    logic [1:0] a;
    logic [1:0] b;
    always_comb
    begin
        a = 2'h0;
        b = 2'h0;
        for (int c = 0; c < 4; c++)
        begin
            for (int s = 0; s < 40; s++)
            begin
                a = common_lvl_ff[2*c+:2];
                b = segment_lvl_ff[2*s+:2];
                // an open common has no electrode connected
                full_on[c*40+s] = !common_open_ff[c] && ({a, b} == 4'hc || {a, b} == 4'h3);
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/lcd_segment_common_driver_assertions.sv
// port-level property checker for the segment/common lcd driver
`default_nettype none
module lcd_drv_checker #(
    parameter int CLK_EXP_BASE = 14
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // cpu data bus
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata_ff,
    input wire logic bus_rvalid_ff,
    // panel drive
    input wire logic [7:0] common_lvl_ff,
    input wire logic [3:0] common_open_ff,
    input wire logic [79:0] segment_lvl_ff,
    input wire logic drive_supply_switch_ff,
    input wire logic panel_scan_clock_ff
);
    logic [7:0] mode_ff;
    logic [2:0] calm_ff;
    logic mode_wr;
    logic settled;
    logic on_st;
    assign mode_wr = bus_wr && bus_addr == 16'hffb0;
    // outputs lag the register by a few cycles, so only judge once it has been quiet
    assign settled = calm_ff >= 3'h4 && !mode_wr;
    assign on_st = settled && mode_ff[7];
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            mode_ff <= 8'h00;
        else if (mode_wr)
            mode_ff <= bus_wdata & 8'h97;
    end
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            calm_ff <= 3'h0;
        else if (mode_wr)
            calm_ff <= 3'h0;
        else if (calm_ff != 3'h7)
            calm_ff <= calm_ff + 3'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_disabled_ground: assert property (
        settled && !mode_ff[7] |-> common_lvl_ff == 8'h00 && segment_lvl_ff == 80'h0
        && common_open_ff == 4'h0) else $error("outputs not grounded while off");
    a_supply_follows: assert property (
        settled |-> drive_supply_switch_ff == mode_ff[4]) else $error("supply switch wrong");
    a_static_same: assert property (
        on_st && mode_ff[2:0] == 3'h4 |-> common_lvl_ff == {4{common_lvl_ff[1:0]}})
        else $error("static commons differ");
    a_open_two: assert property (
        on_st && mode_ff[2:0] == 3'h2 |-> common_open_ff == 4'hc) else $error("open in 2-div");
    a_open_three: assert property (
        on_st && (mode_ff[2:0] == 3'h1 || mode_ff[2:0] == 3'h3) |-> common_open_ff == 4'h8)
        else $error("open in 3-div");
    a_read_answer: assert property (
        bus_rd |-> ##2 bus_rvalid_ff) else $error("read not answered");
    a_clk_reserved: assert property (
        bus_rd && bus_addr == 16'hffb2 |-> ##2 (bus_rdata_ff & 8'hf3) == 8'h00)
        else $error("clock reg reserved bits set");
    a_mode_reserved: assert property (
        bus_rd && bus_addr == 16'hffb0 |-> ##2 (bus_rdata_ff & 8'h68) == 8'h00)
        else $error("mode reg reserved bits set");
    a_dmem_nibble: assert property (
        bus_rd && bus_addr inside {[16'hfa00:16'hfa27]} |-> ##2 bus_rdata_ff[7:4] == 4'h0)
        else $error("memory upper nibble set");
endmodule
bind lcd_segment_common_driver lcd_drv_checker #(.CLK_EXP_BASE(CLK_EXP_BASE)) chk_u (
    .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff),
    .bus_rvalid_ff(bus_rvalid_ff), .common_lvl_ff(common_lvl_ff),
    .common_open_ff(common_open_ff), .segment_lvl_ff(segment_lvl_ff),
    .drive_supply_switch_ff(drive_supply_switch_ff),
    .panel_scan_clock_ff(panel_scan_clock_ff));
`default_nettype wire

// ===== dv/lcd_segment_common_driver_tb.sv
// self-checking bench for the segment/common lcd driver
`default_nettype none
module lcd_segment_common_driver_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // smallest divider that still leaves a half-phase longer than one memory sweep
    localparam int BASE = 6;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata_ff;
    logic bus_rvalid_ff;
    logic [7:0] common_lvl_ff;
    logic [3:0] common_open_ff;
    logic [79:0] segment_lvl_ff;
    logic drive_supply_switch_ff;
    logic panel_scan_clock_ff;
    logic [159:0] full_on;
    int err_total = 0;
    int comparisons = 0;
    int seed = 93826;
    int cycles = 0;
    int mode_m = 0;
    int clk_m = 0;
    int mem_m[40];
    lcd_segment_common_driver #(.CLK_EXP_BASE(BASE)) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_ff(bus_rdata_ff),
        .bus_rvalid_ff(bus_rvalid_ff), .common_lvl_ff(common_lvl_ff),
        .common_open_ff(common_open_ff), .segment_lvl_ff(segment_lvl_ff),
        .drive_supply_switch_ff(drive_supply_switch_ff),
        .panel_scan_clock_ff(panel_scan_clock_ff));
    lcd_panel_model panel_u (.common_lvl_ff(common_lvl_ff), .common_open_ff(common_open_ff),
        .segment_lvl_ff(segment_lvl_ff), .full_on(full_on));
    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [159:0] got, input logic [159:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        bus_wr = 1'b0;
        if (a == 16'hffb0) mode_m = d & 8'h97;
        if (a == 16'hffb2) clk_m = d & 8'h0c;
        if (a >= 16'hfa00 && a <= 16'hfa27) mem_m[a - 16'hfa00] = d & 8'h0f;
    endtask
    function automatic logic [7:0] expect_rd(input logic [15:0] a);
        if (a == 16'hffb0) return 8'(mode_m);
        if (a == 16'hffb2) return 8'(clk_m);
        if (a >= 16'hfa00 && a <= 16'hfa27) return 8'(mem_m[a - 16'hfa00]);
        return 8'h00;
    endfunction
    task automatic rd_chk(input logic [15:0] a);
        @(posedge clk_sys);
        #1;
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        bus_rd = 1'b0;
        @(posedge clk_sys);
        #1;
        chk({bus_rvalid_ff, bus_rdata_ff}, {1'b1, expect_rd(a)});
    endtask
    task automatic watch(input int n);
        int md, div, c, h, prev, hold, chg, last, k, s, b, rise, nrise;
        logic b3, sc_old;
        logic [7:0] old, ce, cm;
        logic [79:0] se;
        logic [159:0] pe;
        md = mode_m % 8;
        div = md == 0 ? 4 : md == 2 ? 2 : md < 4 ? 3 : 1;
        b3 = md < 2;
        prev = div - 1;
        {hold, chg, last, nrise, rise} = '0;
        for (k = 0; k < 200 && common_lvl_ff === 8'h00; k++)
        begin
            @(posedge clk_sys);
            #1;
        end
        old = common_lvl_ff;
        sc_old = panel_scan_clock_ff;
        repeat (n)
        begin
            @(posedge clk_sys);
            #2;
            if (panel_scan_clock_ff && !sc_old)
            begin
                if (nrise > 0) chk(cycles - rise, 1 << (BASE + clk_m / 4));
                nrise++;
                rise = cycles;
            end
            sc_old = panel_scan_clock_ff;
            if (common_lvl_ff !== old)
            begin
                if (chg >= 2) chk(cycles - last, 1 << (BASE + clk_m / 4));
                chg++;
                last = cycles;
                hold = 0;
                old = common_lvl_ff;
            end
            else hold++;
            if (hold == 2)
            begin
                c = 0;
                for (k = 0; k < div; k++)
                    if (common_lvl_ff[2*k+:2] inside {2'h0, 2'h3}) c = k;
                h = common_lvl_ff[2*c+:2] == 2'h0;
                if (div > 1 && c != prev) chk(c, (prev + 1) % div);
                prev = c;
                {ce, cm, pe} = '0;
                for (k = 0; k < 4; k++)
                begin
                    if (k < div || div == 1) cm[2*k+:2] = 2'h3;
                    ce[2*k+:2] = (k == c || div == 1) ? (h ? 2'h0 : 2'h3) : (b3 && h ? 2'h2 : 2'h1);
                end
                for (s = 0; s < 40; s++)
                begin
                    b = (mem_m[s] >> c) & 1;
                    se[2*s+:2] = b ? (h ? 2'h3 : 2'h0) : b3 ? (h ? 2'h1 : 2'h2) : (h ? 2'h0 : 2'h3);
                    for (k = 0; k < 4; k++) pe[k*40+s] = b && (k == c || div == 1);
                end
                chk(common_lvl_ff & cm, ce & cm);
                chk(common_open_ff, div == 2 ? 4'hc : div == 3 ? 4'h8 : 4'h0);
                chk(segment_lvl_ff, se);
                chk(full_on, pe);
            end
        end
    endtask
    initial
    begin
        int i, m;
        repeat (2) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        rd_chk(16'hffb0);
        rd_chk(16'hffb2);
        for (i = 0; i < 6; i++)
        begin
            wr(16'hffb0, {1'b0, 4'($random(seed)), 3'(i % 5)});
            rd_chk(16'hffb0);
            chk(drive_supply_switch_ff, mode_m[4]);
            wr(16'hffb2, 8'($random(seed)));
            rd_chk(16'hffb2);
        end
        wr(16'hfa28, 8'h5a);
        rd_chk(16'hfa28);
        rd_chk(16'hffb1);
        for (m = 0; m < 5; m++)
        begin
            // display off while the memory is refilled, so stale data never shows
            wr(16'hffb0, 8'h10 | 8'(m));
            repeat (4) @(posedge clk_sys);
            #1;
            chk({common_lvl_ff, segment_lvl_ff, common_open_ff}, '0);
            for (i = 0; i < 40; i++) wr(16'hfa00 + 16'(i), 8'($random(seed)) & 8'h0f);
            for (i = 0; i < 40; i++) rd_chk(16'hfa00 + 16'(i));
            repeat (50) @(posedge clk_sys);
            // pin routing and the watch timer sit outside the block and count as set up here
            wr(16'hffb2, 8'(m % 4) << 2);
            wr(16'hffb0, 8'h90 | 8'(m));
            watch(2000);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== verilog/display_mem.sv
// 40 x 4 display data memory, cpu port and scan read port, registered reads
`default_nettype none
module display_mem #(
    parameter int DEPTH = lcd_pkg::NUM_SEG
) (
    // clock
    input wire logic clk_sys,
    // ports
    dmem_if.mem port
);
    logic [lcd_pkg::DMEM_DW-1:0] mem [DEPTH];

    // only the low nibble exists, so nothing else is stored
    always_ff @(posedge clk_sys)
    begin
        if (port.cpu_we)
        begin
            mem[port.cpu_addr] <= port.cpu_wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        port.cpu_rdata <= mem[port.cpu_addr];
    end

    always_ff @(posedge clk_sys)
    begin
        port.scan_data <= mem[port.scan_addr];
    end
endmodule
`default_nettype wire

// ===== verilog/dmem_if.sv
// link between the controller and its display data memory
`default_nettype none
interface dmem_if;
    logic cpu_we;
    logic [lcd_pkg::DMEM_AW-1:0] cpu_addr;
    logic [lcd_pkg::DMEM_DW-1:0] cpu_wdata;
    logic [lcd_pkg::DMEM_DW-1:0] cpu_rdata;
    logic [lcd_pkg::DMEM_AW-1:0] scan_addr;
    logic [lcd_pkg::DMEM_DW-1:0] scan_data;
    modport mem (input cpu_we, cpu_addr, cpu_wdata, scan_addr, output cpu_rdata, scan_data);
    modport ctl (output cpu_we, cpu_addr, cpu_wdata, scan_addr, input cpu_rdata, scan_data);
endinterface
`default_nettype wire

// ===== verilog/lcd_pkg.sv
// constants shared by the segment/common lcd driver and its helpers
`default_nettype none
package lcd_pkg;
    // register map, byte addresses on the cpu data bus
    localparam logic [15:0] DISPLAY_MODE_ADDR = 16'hffb0;
    localparam logic [15:0] CLOCK_CTRL_ADDR = 16'hffb2;
    localparam logic [15:0] DMEM_BASE_ADDR = 16'hfa00;
    localparam logic [15:0] DMEM_LAST_ADDR = 16'hfa27;
    localparam int NUM_SEG = 40;
    localparam int NUM_COM = 4;
    localparam int DMEM_AW = 6;
    localparam int DMEM_DW = 4;

    // display mode register fields
    localparam int DISPLAY_ENABLE_BIT = 7;
    localparam int DRIVE_SUPPLY_BIT = 4;
    localparam int MODE_SEL_LSB = 0;
    localparam logic [7:0] DISPLAY_MODE_RESET = 8'h00;
    localparam logic [7:0] DISPLAY_MODE_MASK = 8'h97;

    // clock control register fields
    localparam int CLK_SEL_LSB = 2;
    localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;
    localparam logic [7:0] CLOCK_CTRL_MASK = 8'h0c;

    // drive mode codes
    localparam logic [2:0] MODE_DIV4_B3 = 3'h0;
    localparam logic [2:0] MODE_DIV3_B3 = 3'h1;
    localparam logic [2:0] MODE_DIV2_B2 = 3'h2;
    localparam logic [2:0] MODE_DIV3_B2 = 3'h3;
    localparam logic [2:0] MODE_STATIC = 3'h4;

    // scan clock = main_osc_freq / 2^(CLK_EXP_BASE + code)
    localparam int CLK_EXP_BASE = 14;
    localparam int CLK_EXP_TOP = 17;

    // level-select codes per output pin
    localparam logic [1:0] LVL_GND = 2'h0;
    localparam logic [1:0] LVL_LOWER_MID = 2'h1;
    localparam logic [1:0] LVL_UPPER_MID = 2'h2;
    localparam logic [1:0] LVL_TOP = 2'h3;
endpackage
`default_nettype wire

// ===== verilog/lcd_segment_common_driver.sv
// segment/common lcd controller: registers, display memory access, drive waveforms
// Contract
// - mode register clears to zero on reset
// - bit7 enables display, bit4 drive supply
// - mode field picks division and bias
// - clock register resets zero, bits 3:2 only
// - scan clock is main clock over power of two
// - frame rate halves per clock code step
// - forty display bytes from base address
// - unused display bytes act as ram
// - display bytes upper nibble reads zero
// - commons selected in ascending order, repeating
// - static mode drives same wave on every common
// - unused commons left open in 2/3-division
// - segment takes bit n in phase n
// - bit one selects, zero deselects segment
// - unscanned memory bits ignored by display
// - full drive only when both selected
// - halves swap levels, no net dc
// - each half-phase lasts one scan period
`default_nettype none
module lcd_segment_common_driver #(
    parameter int CLK_EXP_BASE = lcd_pkg::CLK_EXP_BASE
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // cpu data bus
    input wire logic [15:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata_ff,
    output logic bus_rvalid_ff,
    // panel drive
    output logic [2*lcd_pkg::NUM_COM-1:0] common_lvl_ff,
    output logic [lcd_pkg::NUM_COM-1:0] common_open_ff,
    output logic [2*lcd_pkg::NUM_SEG-1:0] segment_lvl_ff,
    output logic drive_supply_switch_ff,
    output logic panel_scan_clock_ff
);
    localparam int NS = lcd_pkg::NUM_SEG;
    localparam int NC = lcd_pkg::NUM_COM;

    dmem_if mif ();

    logic [7:0] display_mode_reg_ff;
    logic [7:0] drive_clock_ctrl_reg_ff;
    logic [7:0] reg_rdata_ff;
    logic mem_rd_ff;
    logic rd_ff;
    logic tick;
    logic scan_clk;
    logic mem_hit;
    logic [lcd_pkg::DMEM_AW-1:0] mem_idx;
    logic display_enable;
    logic [2:0] mode_sel;
    logic [1:0] clk_sel;
    logic bias_third;
    logic [1:0] last_phase;
    logic [1:0] phase_ff;
    logic half_ff;
    logic [1:0] nxt_phase;
    logic [lcd_pkg::DMEM_AW-1:0] sweep_ff;
    logic [lcd_pkg::DMEM_AW-1:0] sweep_d_ff;
    logic [NS-1:0] stage_ff;
    logic [NS-1:0] seg_sel_ff;

    display_mem #(.DEPTH(NS)) u_mem (
        .clk_sys(clk_sys),
        .port(mif.mem)
    );

    scan_clock_div #(.EXP_BASE(CLK_EXP_BASE)) u_div (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clk_sel(clk_sel),
        .tick_ff(tick),
        .scan_clk_ff(scan_clk)
    );

    // register decode
    always_comb
    begin
        display_enable = display_mode_reg_ff[lcd_pkg::DISPLAY_ENABLE_BIT];
        mode_sel = display_mode_reg_ff[lcd_pkg::MODE_SEL_LSB +: 3];
        clk_sel = drive_clock_ctrl_reg_ff[lcd_pkg::CLK_SEL_LSB +: 2];
        mem_hit = (bus_addr >= lcd_pkg::DMEM_BASE_ADDR) &&
            (bus_addr <= lcd_pkg::DMEM_LAST_ADDR);
        mem_idx = lcd_pkg::DMEM_AW'(bus_addr - lcd_pkg::DMEM_BASE_ADDR);
    end

    // division count and bias; a prohibited code falls back to static
    always_comb
    begin
        bias_third = 1'b0;
        last_phase = 2'h0;
        case (mode_sel)
            lcd_pkg::MODE_DIV4_B3:
            begin
                bias_third = 1'b1;
                last_phase = 2'h3;
            end
            lcd_pkg::MODE_DIV3_B3:
            begin
                bias_third = 1'b1;
                last_phase = 2'h2;
            end
            lcd_pkg::MODE_DIV2_B2:
            begin
                last_phase = 2'h1;
            end
            lcd_pkg::MODE_DIV3_B2:
            begin
                last_phase = 2'h2;
            end
            default:
            begin
                last_phase = 2'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            display_mode_reg_ff <= lcd_pkg::DISPLAY_MODE_RESET;
        else if (bus_wr && bus_addr == lcd_pkg::DISPLAY_MODE_ADDR)
            display_mode_reg_ff <= bus_wdata & lcd_pkg::DISPLAY_MODE_MASK;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            drive_clock_ctrl_reg_ff <= lcd_pkg::CLOCK_CTRL_RESET;
        else if (bus_wr && bus_addr == lcd_pkg::CLOCK_CTRL_ADDR)
            drive_clock_ctrl_reg_ff <= bus_wdata & lcd_pkg::CLOCK_CTRL_MASK;
    end

    // cpu side of the memory; the scan port never blocks software access
    always_comb
    begin
        mif.cpu_we = bus_wr && mem_hit;
        mif.cpu_addr = mem_hit ? mem_idx : '0;
        mif.cpu_wdata = bus_wdata[lcd_pkg::DMEM_DW-1:0];
        mif.scan_addr = sweep_ff;
    end

    // reads take two cycles so that memory and registers share one output flop
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_ff <= 1'b0;
            mem_rd_ff <= 1'b0;
            reg_rdata_ff <= 8'h00;
        end
        else
        begin
            rd_ff <= bus_rd;
            mem_rd_ff <= bus_rd && mem_hit;
            if (bus_addr == lcd_pkg::DISPLAY_MODE_ADDR)
                reg_rdata_ff <= display_mode_reg_ff;
            else if (bus_addr == lcd_pkg::CLOCK_CTRL_ADDR)
                reg_rdata_ff <= drive_clock_ctrl_reg_ff;
            else
                reg_rdata_ff <= 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_rdata_ff <= 8'h00;
            bus_rvalid_ff <= 1'b0;
        end
        else
        begin
            bus_rvalid_ff <= rd_ff;
            if (!rd_ff)
                bus_rdata_ff <= 8'h00;
            else if (mem_rd_ff)
                bus_rdata_ff <= {4'h0, mif.cpu_rdata};
            else
                bus_rdata_ff <= reg_rdata_ff;
        end
    end

    // phase sequencer, restarts at common 0 whenever the display is off
    always_comb
    begin
        nxt_phase = (phase_ff >= last_phase) ? 2'h0 : phase_ff + 2'h1;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            phase_ff <= 2'h0;
            half_ff <= 1'b0;
        end
        else if (!display_enable)
        begin
            phase_ff <= 2'h0;
            half_ff <= 1'b0;
        end
        else if (tick)
        begin
            half_ff <= ~half_ff;
            if (half_ff)
                phase_ff <= nxt_phase;
        end
    end

    // sweep the memory continuously, gathering bit n of the coming phase;
    // a full sweep takes 40 cycles, so a phase must be longer than that:
    // keep CLK_EXP_BASE at 6 or above even in simulation
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sweep_ff <= '0;
            sweep_d_ff <= '0;
        end
        else
        begin
            sweep_ff <= (sweep_ff == lcd_pkg::DMEM_AW'(NS - 1)) ? '0 :
                sweep_ff + lcd_pkg::DMEM_AW'(1);
            sweep_d_ff <= sweep_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            stage_ff <= '0;
        else
            // while off, gather phase 0 so the first phase after enable shows its own bit
            stage_ff[sweep_d_ff] <= mif.scan_data[display_enable ? nxt_phase : phase_ff];
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            seg_sel_ff <= '0;
        else if (!display_enable || (tick && half_ff))
            seg_sel_ff <= stage_ff;
    end

    // level code of one segment from its select bit
    function automatic logic [1:0] seg_level(input logic sel, input logic half,
                                             input logic third);
        logic [1:0] lvl;
        lvl = lcd_pkg::LVL_GND;
        if (sel)
            lvl = half ? lcd_pkg::LVL_TOP : lcd_pkg::LVL_GND;
        else if (third)
            lvl = half ? lcd_pkg::LVL_LOWER_MID : lcd_pkg::LVL_UPPER_MID;
        else
            lvl = half ? lcd_pkg::LVL_GND : lcd_pkg::LVL_TOP;
        return lvl;
    endfunction

    // level code of one common; only a selected common reaches the rails
    function automatic logic [1:0] com_level(input logic sel, input logic half,
                                             input logic third);
        logic [1:0] lvl;
        lvl = lcd_pkg::LVL_GND;
        if (sel)
            lvl = half ? lcd_pkg::LVL_GND : lcd_pkg::LVL_TOP;
        else if (third)
            lvl = half ? lcd_pkg::LVL_UPPER_MID : lcd_pkg::LVL_LOWER_MID;
        else
            lvl = lcd_pkg::LVL_LOWER_MID;
        return lvl;
    endfunction

    genvar gs;
    generate
        for (gs = 0; gs < NS; gs++)
        begin : g_seg
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                    segment_lvl_ff[2*gs +: 2] <= lcd_pkg::LVL_GND;
                else if (!display_enable)
                    segment_lvl_ff[2*gs +: 2] <= lcd_pkg::LVL_GND;
                else
                    segment_lvl_ff[2*gs +: 2] <= seg_level(seg_sel_ff[gs], half_ff,
                        bias_third);
            end
        end
    endgenerate

    genvar gc;
    generate
        for (gc = 0; gc < NC; gc++)
        begin : g_com
            logic used;
            logic sel;
            always_comb
            begin
                used = (2'(gc) <= last_phase) || (last_phase == 2'h0);
                sel = (last_phase == 2'h0) || (phase_ff == 2'(gc));
            end

            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    common_lvl_ff[2*gc +: 2] <= lcd_pkg::LVL_GND;
                    common_open_ff[gc] <= 1'b0;
                end
                else if (!display_enable)
                begin
                    common_lvl_ff[2*gc +: 2] <= lcd_pkg::LVL_GND;
                    common_open_ff[gc] <= 1'b0;
                end
                else
                begin
                    common_lvl_ff[2*gc +: 2] <= used ?
                        com_level(sel, half_ff, bias_third) : lcd_pkg::LVL_GND;
                    common_open_ff[gc] <= ~used;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            drive_supply_switch_ff <= 1'b0;
            panel_scan_clock_ff <= 1'b0;
        end
        else
        begin
            drive_supply_switch_ff <= display_mode_reg_ff[lcd_pkg::DRIVE_SUPPLY_BIT];
            panel_scan_clock_ff <= scan_clk;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/scan_clock_div.sv
// power-of-two divider giving the panel scan clock and a tick per period
`default_nettype none
module scan_clock_div #(
    parameter int EXP_BASE = lcd_pkg::CLK_EXP_BASE
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // control
    input wire logic [1:0] clk_sel,
    // outputs
    output logic tick_ff,
    output logic scan_clk_ff
);
    localparam int CW = EXP_BASE + 3;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] mask;
    logic [CW-1:0] half_bit;

    always_comb
    begin
        mask = CW'((33'h1 << (EXP_BASE + int'(clk_sel))) - 33'h1);
        half_bit = CW'(33'h1 << (EXP_BASE - 1 + int'(clk_sel)));
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            cnt_ff <= '0;
        else
            cnt_ff <= cnt_ff + CW'(1);
    end

    // one tick per selected period, so every half-phase is one scan clock period
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            tick_ff <= 1'b0;
        else
            tick_ff <= ((cnt_ff & mask) == mask);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            scan_clk_ff <= 1'b0;
        else
            scan_clk_ff <= |(cnt_ff & half_bit);
    end
endmodule
`default_nettype wire
